// >>> shared/pew_pkg.sv
// package: pin timing, geometry and command codes for the parallel eeprom host controller
package pew_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;              // 100 MHz system clock
  localparam int WE_PULSE_NS       = 100;             // strobe low time, well above the noise filter
  localparam int WE_PULSE_CYC      = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_NS          = 50;              // address/data setup and hold margin
  localparam int SETUP_CYC         = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACC_NS       = 250;             // slowest read access time
  localparam int READ_ACC_CYC      = (READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_LOAD_US      = 150;             // byte_load_window, longest gap between loads
  localparam int BYTE_LOAD_CYC     = (BYTE_LOAD_US * 1000) / CLK_PERIOD_NS;
  localparam int PROG_CYCLE_MS     = 10;              // program_cycle_time
  localparam int PROG_CYCLE_CYC    = (PROG_CYCLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int POWER_ON_MS       = 5;               // power-on write hold-off
  localparam int POWER_ON_CYC      = (POWER_ON_MS * 1000000) / CLK_PERIOD_NS;
  localparam int TIMER_W           = 24;              // wide enough for every count above
  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int ADDR_W            = 13;
  localparam int DATA_W            = 8;
  localparam int PAGE_BYTES        = 64;
  localparam int INPAGE_W          = 6;               // byte_in_page_bits
  localparam int POLL_BIT          = 7;               // poll_status_bit
  localparam int TOGGLE_BIT        = 6;               // toggle_status_bit
  localparam logic [ADDR_W-1:0] ID_BASE = 13'h1FC0;   // identification bytes start
  // ------------------------------------------------------------
  // software_write_lock command bytes (values fixed in this package)
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] LOCK_ADDR0 = 13'h1555;
  localparam logic [ADDR_W-1:0] LOCK_ADDR1 = 13'h0AAA;
  localparam logic [ADDR_W-1:0] LOCK_ADDR2 = 13'h1555;
  localparam logic [DATA_W-1:0] LOCK_DATA0 = 8'hAA;
  localparam logic [DATA_W-1:0] LOCK_DATA1 = 8'h55;
  localparam logic [DATA_W-1:0] LOCK_DATA2 = 8'hA0;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 8'h20;
  // ------------------------------------------------------------
  // host commands
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PEW_CMD_READ,        // single read
    PEW_CMD_WRITE,       // page write of CMD_LEN bytes
    PEW_CMD_LOCK,        // enable software_write_lock
    PEW_CMD_UNLOCK       // disable software_write_lock
  } pew_cmd_t;
endpackage : pew_pkg

// >>> src/pew_host.sv
// host controller that drives a byte-wide parallel eeprom through its strobes
// Contract
// - write by strobe pulse, gate high
// - page load of up to 64 bytes
// - next byte within byte load window
// - page bits fixed during one load
// - lock by three-byte command sequence
// - locked writes need command prefix
// - commands use page-load timing
// - id bytes at top with high line
module pew_host
  import pew_pkg::*;
#(
  parameter int PROG_TIMEOUT = PROG_CYCLE_CYC,   // give-up bound for polling
  parameter int POWER_WAIT   = POWER_ON_CYC      // hold-off after reset
) (
  input  wire logic                   CLOCK,
  input  wire logic                   RESETN,
  input  wire pew_pkg::pew_cmd_t      CMD,          // command code
  input  wire logic                   CMD_VALID,    // one-cycle request
  input  wire logic [ADDR_W-1:0]      CMD_ADDR,     // start address
  input  wire logic [INPAGE_W:0]      CMD_LEN,      // bytes 1..64 for a write
  input  wire logic                   CMD_ID,       // reach identification bytes
  input  wire logic                   CMD_PREFIX,   // precede write with lock sequence
  input  wire logic                   BUF_WR,       // stage one byte
  input  wire logic [INPAGE_W-1:0]    BUF_ADDR,
  input  wire logic [DATA_W-1:0]      BUF_DATA,
  output logic                        BUSY,
  output logic                        DONE,         // one-cycle pulse
  output logic                        TIMEOUT,      // with DONE, poll gave up
  output logic [DATA_W-1:0]           RD_DATA,
  output logic [ADDR_W-1:0]           MEM_ADDR,
  output logic                        MEM_CE_N,
  output logic                        MEM_OE_N,
  output logic                        MEM_WE_N,
  output logic                        MEM_ID_HV,    // id_access_addr_line raised
  input  wire logic [DATA_W-1:0]      MEM_DQ_I,
  output logic [DATA_W-1:0]           MEM_DQ_O,
  output logic                        MEM_DQ_OE
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_POWER, S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_NEXT, S_RD_WAIT, S_RD_TAKE, S_POLL, S_POLL_TAKE
  } pew_state_t;

  pew_state_t           state_q, state_d;
  logic [TIMER_W-1:0]   tmr_q, tmr_d;          // phase timer
  logic [TIMER_W-1:0]   wait_q, wait_d;        // programming time spent polling
  pew_cmd_t             cmd_q, cmd_d;
  logic [ADDR_W-1:0]    base_q, base_d;        // page_select_bits kept from here
  logic [INPAGE_W:0]    len_q, len_d;
  logic [INPAGE_W:0]    idx_q, idx_d;          // load step counter, prefix included
  logic                 id_q, id_d;
  logic                 pre_q, pre_d;
  logic [DATA_W-1:0]    last_q, last_d;        // last byte written, for polling
  logic                 tgl_q, tgl_d;          // previous toggle_status_bit
  logic                 tgl_ok_q, tgl_ok_d;    // a first poll sample exists
  logic                 stay_q, stay_d;        // toggle bit was already steady at the previous sample
  logic                 tgl_same;              // toggle bit equals the previous sample
  logic                 busy_d, done_d, tout_d;
  logic [DATA_W-1:0]    rdat_d;
  logic [ADDR_W-1:0]    addr_d;
  logic                 ce_d, oe_d, we_d, hv_d;
  logic [DATA_W-1:0]    dqo_d;
  logic                 dqoe_d;
  logic [DATA_W-1:0]    dq_s1_q, dq_s2_q, dq_s3_q; // pin synchroniser
  logic [INPAGE_W-1:0]  buf_rd_addr;
  logic [DATA_W-1:0]    buf_rd_data;
  logic [INPAGE_W:0]    pre_steps;             // command bytes before data
  logic                 stable;

  // ------------------------------------------------------------
  // staging buffer
  // ------------------------------------------------------------
  pew_page_buf #(.DEPTH(PAGE_BYTES), .AW(INPAGE_W), .DW(DATA_W)) u_buf (
    .clk       (CLOCK),
    .wr_en     (BUF_WR),
    .wr_addr   (BUF_ADDR),
    .wr_data   (BUF_DATA),
    .rd_addr   (buf_rd_addr),
    .rd_data_q (buf_rd_data)
  );

  // ------------------------------------------------------------
  // read data synchroniser, a change counts when stages 2 and 3 agree
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else begin
      dq_s1_q <= MEM_DQ_I;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end
  assign stable = (dq_s2_q == dq_s3_q);
  // a busy device flips the toggle bit on every read, so two equal samples mean it has finished
  assign tgl_same = tgl_ok_q && (dq_s3_q[TOGGLE_BIT] == tgl_q);

  // lock sequence is three bytes when used, then the data bytes follow
  assign pre_steps = (cmd_q == PEW_CMD_WRITE && !pre_q) ? 7'd0 : 7'd3;
  // buffer byte index of the current data step; the buffer read lags one cycle
  assign buf_rd_addr = idx_q[INPAGE_W-1:0] - pre_steps[INPAGE_W-1:0];

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;  tmr_d = tmr_q;  wait_d = wait_q;  cmd_d = cmd_q;
    base_d = base_q;  len_d = len_q;  idx_d = idx_q;  id_d = id_q;  pre_d = pre_q;
    last_d = last_q;  tgl_d = tgl_q;  tgl_ok_d = tgl_ok_q;  stay_d = stay_q;
    busy_d = BUSY;  done_d = 1'b0;  tout_d = TIMEOUT;  rdat_d = RD_DATA;
    addr_d = MEM_ADDR;  ce_d = MEM_CE_N;  oe_d = MEM_OE_N;  we_d = MEM_WE_N;
    hv_d = MEM_ID_HV;  dqo_d = MEM_DQ_O;  dqoe_d = MEM_DQ_OE;
    if (tmr_q != '0) tmr_d = tmr_q - 1'b1;
    if (state_q == S_POLL || state_q == S_POLL_TAKE) wait_d = wait_q + 1'b1;
    case (state_q)
      // supply just came up: hold off every write
      S_POWER: begin
        busy_d = 1'b1;
        if (tmr_q == '0) begin
          state_d = S_IDLE;
          busy_d = 1'b0;
        end
      end
      // accept a command; the lock state is the device's, kept across power
      S_IDLE: begin
        if (CMD_VALID) begin
          cmd_d = CMD;  base_d = CMD_ADDR;  id_d = CMD_ID;  pre_d = CMD_PREFIX;
          len_d = (CMD_LEN == '0) ? 7'd1 : ((CMD_LEN > 7'd64) ? 7'd64 : CMD_LEN);
          idx_d = '0;  busy_d = 1'b1;  tout_d = 1'b0;
          hv_d = CMD_ID;
          addr_d = CMD_ID ? (ID_BASE | CMD_ADDR) : CMD_ADDR;
          oe_d = (CMD == PEW_CMD_READ) ? 1'b0 : 1'b1;
          ce_d = 1'b1;
          tmr_d = TIMER_W'(SETUP_CYC);
          state_d = (CMD == PEW_CMD_READ) ? S_RD_WAIT : S_SETUP;
          if (CMD == PEW_CMD_READ) ce_d = 1'b0;
        end
      end
      // place address and data of one load step, gate held high
      S_SETUP: begin
        if (idx_q < pre_steps) begin
          addr_d = (idx_q == 7'd1) ? LOCK_ADDR1 : ((idx_q == 7'd0) ? LOCK_ADDR0 : LOCK_ADDR2);
          dqo_d = (idx_q == 7'd0) ? LOCK_DATA0 : ((idx_q == 7'd1) ? LOCK_DATA1 :
                  ((cmd_q == PEW_CMD_UNLOCK) ? UNLOCK_DATA2 : LOCK_DATA2));
        end else begin
          // page bits from the start address, or from ID_BASE for id bytes; byte from the step
          addr_d = {base_q[ADDR_W-1:INPAGE_W], buf_rd_addr} | (id_q ? ID_BASE : 13'h0000);
          dqo_d = buf_rd_data;
          last_d = buf_rd_data;
        end
        dqoe_d = 1'b1;
        ce_d = 1'b0;
        oe_d = 1'b1;
        if (tmr_q == '0) begin
          we_d = 1'b0;
          tmr_d = TIMER_W'(WE_PULSE_CYC);
          state_d = S_STROBE;
        end
      end
      // strobe held low long past the noise filter
      S_STROBE: begin
        if (tmr_q == '0) begin
          we_d = 1'b1;
          tmr_d = TIMER_W'(SETUP_CYC);
          state_d = S_HOLD;
        end
      end
      // data hold, then the next step well inside the byte load window
      S_HOLD: begin
        if (tmr_q == '0) begin
          idx_d = idx_q + 1'b1;
          state_d = S_NEXT;
        end
      end
      S_NEXT: begin
        if (cmd_q != PEW_CMD_WRITE && idx_q == 7'd3) begin
          ce_d = 1'b1;  dqoe_d = 1'b0;
          tmr_d = TIMER_W'(PROG_TIMEOUT);  // lock takes one program cycle
          state_d = S_POLL_TAKE;  tgl_ok_d = 1'b0;  wait_d = '0;  stay_d = 1'b0;
          last_d = (cmd_q == PEW_CMD_UNLOCK) ? UNLOCK_DATA2 : LOCK_DATA2;
        end else if (cmd_q == PEW_CMD_WRITE && idx_q == len_q + pre_steps) begin
          // stop loading; the device starts programming once the window lapses
          ce_d = 1'b1;  dqoe_d = 1'b0;
          wait_d = '0;  tgl_ok_d = 1'b0;  stay_d = 1'b0;
          state_d = S_POLL_TAKE;
        end else begin
          tmr_d = TIMER_W'(SETUP_CYC);
          state_d = S_SETUP;
        end
      end
      // single read: wait the access time then sample
      S_RD_WAIT: begin
        if (tmr_q == '0) begin
          tmr_d = TIMER_W'(READ_ACC_CYC);
          state_d = S_RD_TAKE;
        end
      end
      S_RD_TAKE: begin
        if (tmr_q == '0 && stable) begin
          rdat_d = dq_s3_q;
          ce_d = 1'b1;  oe_d = 1'b1;
          busy_d = 1'b0;  done_d = 1'b1;  hv_d = 1'b0;
          state_d = S_IDLE;
        end
      end
      // start one status read of the last location written
      S_POLL_TAKE: begin
        if (wait_q >= TIMER_W'(PROG_TIMEOUT)) begin
          tout_d = 1'b1;  done_d = 1'b1;  busy_d = 1'b0;
          ce_d = 1'b1;  oe_d = 1'b1;  hv_d = 1'b0;
          state_d = S_IDLE;
        end else begin
          ce_d = 1'b0;  oe_d = 1'b0;
          tmr_d = TIMER_W'(READ_ACC_CYC);
          state_d = S_POLL;
        end
      end
      // judge the status byte: toggle bit still and poll bit true means done; a refused
      // write or a command never shows its byte, so a toggle bit still over three samples also ends it
      S_POLL: begin
        if (tmr_q == '0 && stable) begin
          ce_d = 1'b1;  oe_d = 1'b1;
          tgl_d = dq_s3_q[TOGGLE_BIT];
          tgl_ok_d = 1'b1;
          stay_d = tgl_same;
          state_d = S_POLL_TAKE;
          if (tgl_same &&
              (dq_s3_q[POLL_BIT] == last_q[POLL_BIT] || stay_q)) begin
            rdat_d = dq_s3_q;
            done_d = 1'b1;  busy_d = 1'b0;  hv_d = 1'b0;
            state_d = S_IDLE;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= S_POWER;  tmr_q <= TIMER_W'(POWER_WAIT);  wait_q <= '0;
      cmd_q <= PEW_CMD_READ;  base_q <= '0;  len_q <= '0;  idx_q <= '0;
      id_q <= 1'b0;  pre_q <= 1'b0;  last_q <= '0;  tgl_q <= 1'b0;  tgl_ok_q <= 1'b0;  stay_q <= 1'b0;
      BUSY <= 1'b1;  DONE <= 1'b0;  TIMEOUT <= 1'b0;  RD_DATA <= '0;  MEM_ADDR <= '0;
      MEM_CE_N <= 1'b1;  MEM_OE_N <= 1'b1;  MEM_WE_N <= 1'b1;  MEM_ID_HV <= 1'b0;
      MEM_DQ_O <= '0;  MEM_DQ_OE <= 1'b0;
    end else begin
      state_q <= state_d;  tmr_q <= tmr_d;  wait_q <= wait_d;
      cmd_q <= cmd_d;  base_q <= base_d;  len_q <= len_d;  idx_q <= idx_d;
      id_q <= id_d;  pre_q <= pre_d;  last_q <= last_d;  tgl_q <= tgl_d;  tgl_ok_q <= tgl_ok_d;  stay_q <= stay_d;
      BUSY <= busy_d;  DONE <= done_d;  TIMEOUT <= tout_d;  RD_DATA <= rdat_d;  MEM_ADDR <= addr_d;
      MEM_CE_N <= ce_d;  MEM_OE_N <= oe_d;  MEM_WE_N <= we_d;  MEM_ID_HV <= hv_d;
      MEM_DQ_O <= dqo_d;  MEM_DQ_OE <= dqoe_d;
    end
  end
endmodule // pew_host

// >>> src/pew_page_buf.sv
// page buffer: one page of write data staged by the user before a page load
module pew_page_buf #(
  parameter int DEPTH = 64,
  parameter int AW    = 6,
  parameter int DW    = 8
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data_q
);
  // ------------------------------------------------------------
  // storage, read data registered
  // ------------------------------------------------------------
  logic [DW-1:0] mem [DEPTH];           // page bytes, no reset needed

  // write port and registered read port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule // pew_page_buf

// >>> test/pew_eeprom_model.sv
// behavioural model of the byte-wide eeprom, timed by the bench clock
module pew_eeprom_model
  import pew_pkg::*;
#(
  parameter int PROG = 300,
  parameter int BLW  = 60,
  parameter int PWR  = 5
) (
  input  wire logic              clk,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              id_hv,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out
);
  logic [7:0]  mem [int];   // erased cells read FF
  logic [7:0]  pg_d [64];   // page latch
  logic [63:0] pg_v = '0;
  logic [12:0] a_l, pg_a;
  logic [7:0]  last = '0, drv_q = '0;
  logic w_q = 0, r_q = 0, tog_q = 0, locked = 0, unlock = 0, pg_id = 0, loading = 0, have_pg = 0;
  int load_t = 0, prog_t = 0, pwr_t = 0, seq = 0, page_err = 0;
  wire w = !ce_n && !we_n && oe_n;
  wire r = !ce_n && !oe_n && we_n;
  wire busy = loading || prog_t != 0;
  function automatic int key(logic id, logic [12:0] a);
    return (id && a >= ID_BASE) ? 8192 + a[5:0] : a;
  endfunction
  // released bus shows no stale value
  always_comb begin
    if (!r) dq_out = ~drv_q;
    else if (busy) dq_out = {~last[7], tog_q, last[5:0]};
    else dq_out = mem.exists(key(id_hv, addr)) ? mem[key(id_hv, addr)] : 8'hFF;
  end
  always @(posedge clk) begin
    w_q <= w;
    r_q <= r;
    pwr_t <= pwr_t + 1;
    if (r) drv_q <= dq_out;
    if (r && !r_q) tog_q <= ~tog_q;
    if (w && !w_q) a_l <= addr;
    if (!w && w_q && pwr_t > PWR && prog_t == 0) begin
      loading <= 1;
      load_t <= BLW;
      last <= dq_in;
      if (seq < 3 && a_l == (seq == 0 ? LOCK_ADDR0 : seq == 1 ? LOCK_ADDR1 : LOCK_ADDR2)
          && dq_in == (seq == 0 ? LOCK_DATA0 : seq == 1 ? LOCK_DATA1 : LOCK_DATA2)) seq <= seq + 1;
      else if (seq == 2 && a_l == LOCK_ADDR2 && dq_in == UNLOCK_DATA2) begin
        seq <= 3;
        unlock <= 1;
      end else begin
        if (have_pg && a_l[12:6] != pg_a[12:6]) page_err <= page_err + 1;
        pg_d[a_l[5:0]] <= dq_in;
        pg_v[a_l[5:0]] <= 1;
        pg_a <= a_l;
        pg_id <= id_hv;
        have_pg <= 1;
      end
    end else if (loading && load_t > 1) load_t <= load_t - 1;
    else if (loading) begin
      loading <= 0;
      prog_t <= PROG;
    end else if (prog_t > 1) prog_t <= prog_t - 1;
    else if (prog_t == 1) begin
      for (int i = 0; i < 64; i++)
        if (pg_v[i] && (!locked || seq == 3)) mem[key(pg_id, {pg_a[12:6], i[5:0]})] = pg_d[i];
      locked <= (seq == 3) ? !unlock : locked;
      prog_t <= 0;
      seq <= 0;
      unlock <= 0;
      pg_v <= '0;
      have_pg <= 0;
    end
  end
endmodule // pew_eeprom_model

// >>> test/pew_host_props.sv
// checker: pin-level assertions on the eeprom host controller
module pew_host_props
  import pew_pkg::*;
#(
  parameter int POWER_WAIT = 10
) (
  input wire logic              CLOCK,
  input wire logic              RESETN,
  input wire logic              DONE,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic              MEM_CE_N,
  input wire logic              MEM_OE_N,
  input wire logic              MEM_WE_N,
  input wire logic              MEM_ID_HV,
  input wire logic [DATA_W-1:0] MEM_DQ_O,
  input wire logic              MEM_DQ_OE
);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic we_q;          // strobe one cycle ago
  int   gap_q, gap_d;  // cycles since last strobe fall in this op
  int   pwr_q, pwr_d;  // cycles since reset, saturating
  // gap restarts at each strobe fall and clears at the end of an op
  always_comb begin
    gap_d = (we_q && !MEM_WE_N) ? 1 : (DONE || gap_q == 0) ? 0 : gap_q + 1;
    pwr_d = (pwr_q < POWER_WAIT) ? pwr_q + 1 : pwr_q;
  end
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      we_q  <= 1'b1;
      gap_q <= 0;
      pwr_q <= 0;
    end else begin
      we_q  <= MEM_WE_N;
      gap_q <= gap_d;
      pwr_q <= pwr_d;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // a strobe pulse must outlast the device noise filter by far
  sequence s_we_pulse; !MEM_WE_N [*8]; endsequence
  sequence s_we_fall; $fell(MEM_WE_N); endsequence
  property p_read_mode; !MEM_OE_N |-> MEM_WE_N && !MEM_DQ_OE; endproperty
  property p_no_contend; MEM_DQ_OE |-> MEM_OE_N; endproperty
  property p_write_mode; !MEM_WE_N |-> !MEM_CE_N && MEM_OE_N && MEM_DQ_OE; endproperty
  property p_we_width; s_we_fall |-> s_we_pulse; endproperty
  property p_latch_stable; !$past(MEM_WE_N) |-> $stable(MEM_ADDR) && $stable(MEM_DQ_O); endproperty
  property p_load_gap; s_we_fall ##0 gap_q != 0 |-> gap_q < BYTE_LOAD_CYC; endproperty
  property p_power_hold; s_we_fall |-> pwr_q == POWER_WAIT; endproperty
  property p_id_range; MEM_ID_HV && !MEM_CE_N |-> MEM_ADDR >= ID_BASE; endproperty
  a_read_mode: assert property (p_read_mode) else $error("read with write strobe or bus driven");
  a_no_contend: assert property (p_no_contend) else $error("bus driven while gate low");
  a_write_mode: assert property (p_write_mode) else $error("write strobe outside write mode");
  a_we_width: assert property (p_we_width) else $error("write strobe too short");
  a_latch_stable: assert property (p_latch_stable) else $error("address or data moved under strobe");
  a_load_gap: assert property (p_load_gap) else $error("byte load gap too long");
  a_power_hold: assert property (p_power_hold) else $error("write before power-on hold");
  a_id_range: assert property (p_id_range) else $error("id access outside id range");
endmodule // pew_host_props
bind pew_host pew_host_props #(.POWER_WAIT(POWER_WAIT)) u_props (.CLOCK(CLOCK), .RESETN(RESETN),
  .DONE(DONE), .MEM_ADDR(MEM_ADDR), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N),
  .MEM_ID_HV(MEM_ID_HV), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE));

// >>> test/test_pew_host.sv
// testbench: host controller against the eeprom model
module test_pew_host;
  timeunit 1ns;
  timeprecision 1ps;
  import pew_pkg::*;
  logic CLOCK = 0, RESETN = 0, CMD_VALID = 0, CMD_ID = 0, CMD_PREFIX = 0, BUF_WR = 0;
  pew_cmd_t CMD = PEW_CMD_READ;
  logic [ADDR_W-1:0] CMD_ADDR = '0, MEM_ADDR;
  logic [INPAGE_W:0] CMD_LEN = '0;
  logic [INPAGE_W-1:0] BUF_ADDR = '0;
  logic [DATA_W-1:0] BUF_DATA = '0, RD_DATA, MEM_DQ_O, DEV_Q, BUS;
  logic BUSY, DONE, TIMEOUT, MEM_CE_N, MEM_OE_N, MEM_WE_N, MEM_ID_HV, MEM_DQ_OE;
  int failures = 0;
  int tests_run = 0;
  assign BUS = MEM_DQ_OE ? MEM_DQ_O : DEV_Q; // wire level chosen by the host enable alone
  always #5 CLOCK = ~CLOCK;
  pew_host #(.PROG_TIMEOUT(2000), .POWER_WAIT(10)) dut (.CLOCK(CLOCK), .RESETN(RESETN), .CMD(CMD),
    .CMD_VALID(CMD_VALID), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN), .CMD_ID(CMD_ID), .CMD_PREFIX(CMD_PREFIX),
    .BUF_WR(BUF_WR), .BUF_ADDR(BUF_ADDR), .BUF_DATA(BUF_DATA), .BUSY(BUSY), .DONE(DONE), .TIMEOUT(TIMEOUT),
    .RD_DATA(RD_DATA), .MEM_ADDR(MEM_ADDR), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N),
    .MEM_ID_HV(MEM_ID_HV), .MEM_DQ_I(BUS), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE(MEM_DQ_OE));
  pew_eeprom_model #(.PROG(300), .BLW(60), .PWR(5)) dev (.clk(CLOCK), .ce_n(MEM_CE_N), .oe_n(MEM_OE_N),
    .we_n(MEM_WE_N), .id_hv(MEM_ID_HV), .addr(MEM_ADDR), .dq_in(BUS), .dq_out(DEV_Q));
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one command, then a bounded wait for its done pulse
  task automatic run(pew_cmd_t c, logic [12:0] a, logic [6:0] n, logic id, logic pf);
    int k;
    @(posedge CLOCK);
    CMD <= c;
    {CMD_ADDR, CMD_LEN, CMD_ID, CMD_PREFIX, CMD_VALID} <= {a, n, id, pf, 1'b1};
    @(posedge CLOCK);
    CMD_VALID <= 0;
    for (k = 0; k < 5000; k++) begin
      @(negedge CLOCK);
      if (DONE === 1'b1) break;
    end
    if (k == 5000) failures++;
  endtask
  task automatic stage(int i, logic [7:0] d);
    @(posedge CLOCK);
    {BUF_WR, BUF_ADDR, BUF_DATA} <= {1'b1, i[5:0], d};
    @(posedge CLOCK);
    BUF_WR <= 0;
  endtask
  task automatic rd(logic [12:0] a, logic id, logic [7:0] exp);
    run(PEW_CMD_READ, a, 7'd1, id, 1'b0);
    check(RD_DATA, exp);
  endtask
  // reset held 8 cycles, then the power-on hold must show on busy and end
  task automatic boot();
    @(posedge CLOCK);
    RESETN <= 0;
    repeat (8) @(posedge CLOCK);
    RESETN <= 1;
    @(negedge CLOCK);
    check(BUSY, 8'h01);
    for (int k = 0; k < 100; k++) begin
      @(negedge CLOCK);
      if (BUSY === 1'b0) break;
    end
    check(BUSY, 8'h00);
  endtask
  // full page: both ends of the page and the next page
  task automatic t_page();
    for (int i = 0; i < 64; i++) stage(i, 8'h40 + i[7:0]);
    run(PEW_CMD_WRITE, 13'h0080, 7'd64, 1'b0, 1'b0);
    check(TIMEOUT, 8'h00);
    rd(13'h0080, 1'b0, 8'h40);
    rd(13'h00BF, 1'b0, 8'h7F);
    rd(13'h00C0, 1'b0, 8'hFF);
  endtask
  // single byte: neighbours in the page stay erased
  task automatic t_partial();
    stage(0, 8'h11);
    stage(1, 8'h22);
    run(PEW_CMD_WRITE, 13'h0100, 7'd1, 1'b0, 1'b0);
    rd(13'h0100, 1'b0, 8'h11);
    rd(13'h0101, 1'b0, 8'hFF);
  endtask
  task automatic t_lock();
    check(dev.locked, 8'h00);
    run(PEW_CMD_LOCK, 13'h0000, 7'd1, 1'b0, 1'b0);
    check(TIMEOUT, 8'h00);
    boot();
    stage(0, 8'h5A);
    run(PEW_CMD_WRITE, 13'h0200, 7'd1, 1'b0, 1'b0);
    check(TIMEOUT, 8'h00);
    check(RD_DATA, 8'hFF);
    rd(13'h0200, 1'b0, 8'hFF);
    run(PEW_CMD_WRITE, 13'h0200, 7'd1, 1'b0, 1'b1);
    rd(13'h0200, 1'b0, 8'h5A);
    rd(LOCK_ADDR0, 1'b0, 8'hFF);
    run(PEW_CMD_UNLOCK, 13'h0000, 7'd1, 1'b0, 1'b0);
    stage(0, 8'h3C);
    run(PEW_CMD_WRITE, 13'h0240, 7'd1, 1'b0, 1'b0);
    rd(13'h0240, 1'b0, 8'h3C);
  endtask
  // id bytes live apart from the main array
  task automatic t_id();
    stage(0, 8'h77);
    run(PEW_CMD_WRITE, 13'h0000, 7'd1, 1'b1, 1'b0);
    rd(13'h0000, 1'b1, 8'h77);
    rd(13'h1FC0, 1'b0, 8'hFF);
  endtask
  initial begin
    boot();
    t_page();
    t_partial();
    t_lock();
    t_id();
    check(dev.page_err[7:0], 8'h00);
    give_verdict();
  end
  // about twenty commands of a few hundred cycles each fit well inside this
  initial begin
    #500000;
    failures++;
    give_verdict();
  end
endmodule // test_pew_host
